// >>> dv/bac_checker.sv
`timescale 1ns/1ps
module bac_checker (
   input wire       clock,
   input wire       arst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_write,
   input wire       reg_read,
   input wire       reg_rvalid,
   input wire       low_power_mode,
   input wire [3:0] channel_enable,
   input wire [3:0] capture_done,
   input wire       error_event,
   input wire       range_violation,
   input wire       int_ack,
   input wire       max_output_clear,
   input wire [3:0] button_out,
   input wire       interrupt_output,
   input wire       max_output_flag,
   input wire       raw_data_select,
   input wire       algorithm_state_reset,
   input wire [3:0] baseline_reset
);
   reg  [7:0] ctl_reg;
   reg  [1:0] quiet_reg;
   wire       ctl_wr  = reg_write && reg_addr == 8'h11;
   // Control shadow is trusted only once a write has had time to reach the outputs
   wire       settled = quiet_reg == 2'h0 && !ctl_wr;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctl_reg   <= 8'h18;
         quiet_reg <= 2'h0;
      end else if (ctl_wr) begin
         ctl_reg   <= reg_wdata;
         quiet_reg <= 2'h3;
      end else if (!settled) begin
         quiet_reg <= quiet_reg - 2'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence cap_s;
      settled && raw_data_select && (|(capture_done & channel_enable) || error_event);
   endsequence
   sequence lp_exit_s;
      $fell(low_power_mode);
   endsequence
   rd_answer_a: assert property (reg_read |=> reg_rvalid)
      else $error("read not answered");
   rd_quiet_a: assert property (!reg_read |=> !reg_rvalid)
      else $error("unrequested read answer");
   raw_pins_a: assert property (raw_data_select |-> button_out == 4'h0)
      else $error("pins active in raw mode");
   cap_int_a: assert property (cap_s |-> ##2 interrupt_output == ctl_reg[2])
      else $error("capture did not interrupt");
   int_hold_a: assert property (settled && interrupt_output == ctl_reg[2] && !int_ack
      && !$past(int_ack)
      |=> interrupt_output == ctl_reg[2]) else $error("interrupt dropped");
   range_flag_a: assert property (settled && range_violation && !ctl_reg[0]
      && !max_output_clear |-> ##[1:2] max_output_flag) else $error("flag not set");
   flag_hold_a: assert property (max_output_flag && !max_output_clear |=> max_output_flag)
      else $error("flag not sticky");
   alg_rst_a: assert property (lp_exit_s |-> ##[1:2] algorithm_state_reset)
      else $error("no algorithm reset");
   base_keep_a: assert property (settled && algorithm_state_reset |->
      baseline_reset == (ctl_reg[4] ? 4'hf : ~channel_enable)) else $error("baseline reset");
endmodule // bac_checker

// >>> dv/bac_host_model.sv
`timescale 1ns/1ps
module bac_host_model (
   input  wire       clock,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_write,
   output reg        reg_read,
   input  wire [7:0] reg_rdata,
   input  wire       reg_rvalid
);
   initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h0;
   // Callers hold conversion off around settings changes
   // and pass reserved bits at their reset values
   task wr(input [7:0] a, input [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clock) #1 reg_write = 1'b0;
      @(posedge clock) #1;
   endtask
   // A missing answer returns unknown data
   task rd(input [7:0] a, output [7:0] d);
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clock) #1 reg_read = 1'b0;
      d = reg_rvalid ? reg_rdata : 8'hxx;
      @(posedge clock) #1;
   endtask
endmodule // bac_host_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg        clock, arst_n, low_power_mode, error_event, range_violation, int_ack;
   reg        max_output_clear;
   reg  [3:0] channel_enable, button_detect, capture_done;
   wire [7:0] reg_addr, reg_wdata, reg_rdata, tracking_pause_and_group;
   wire       reg_write, reg_read, reg_rvalid, interrupt_output, max_output_flag;
   wire       raw_data_select, lp_sample_tick, algorithm_state_reset;
   wire [3:0] button_out, baseline_reset;
   wire [1:0] low_power_rate_code;
   wire [2:0] track_step;
   wire [5:0] channel0_sensitivity, channel1_sensitivity;
   wire [5:0] channel2_sensitivity, channel3_sensitivity;
   integer    n_mismatch, checks, i, n;
   reg  [7:0] d;
   bac_config_regs #(.LP_BASE_CYCLES(8), .TIMEOUT_CYCLES(20)) DUT (.clock, .arst_n, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .low_power_mode,
      .channel_enable, .button_detect, .capture_done, .error_event, .range_violation, .int_ack,
      .max_output_clear, .button_out, .interrupt_output, .max_output_flag, .raw_data_select,
      .lp_sample_tick, .low_power_rate_code, .track_step, .algorithm_state_reset,
      .baseline_reset, .channel0_sensitivity, .channel1_sensitivity, .channel2_sensitivity,
      .channel3_sensitivity, .tracking_pause_and_group);
   bac_host_model host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .reg_rvalid);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task chk(input [23:0] got, input [23:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input integer k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task end_of_test;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task t_reset;
      for (i = 0; i < 9; i = i + 1) begin
         host.rd(8'h0e + i[7:0], d);
         chk(d, 72'h28_10_28_18_28_05_28_03_00 >> (64 - 8 * i) & 8'hff);
      end
      chk({channel0_sensitivity, track_step, interrupt_output}, {6'h28, 3'h3, 1'b1});
      chk(raw_data_select, 1'b0);
   endtask
   task t_rw;
      host.wr(8'h0e, 8'h01);
      host.wr(8'h10, 8'h12);
      host.wr(8'h12, 8'h23);
      host.wr(8'h14, 8'h3f);
      host.wr(8'h16, 8'ha5);
      host.wr(8'h20, 8'hff);
      host.rd(8'h20, d);
      chk(d, 8'h00);
      host.rd(8'h14, d);
      chk(d, 8'h3f);
      chk({channel0_sensitivity, channel1_sensitivity, channel2_sensitivity,
         channel3_sensitivity}, {6'h01, 6'h12, 6'h23, 6'h3f});
      chk(tracking_pause_and_group, 8'ha5);
   endtask
   task t_rate;
      low_power_mode = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(8'h0f, {6'h04, i[1:0]});
         for (n = 0; n < 200 && lp_sample_tick !== 1'b1; n = n + 1) cyc(1);
         cyc(1);
         for (n = 1; n < 200 && lp_sample_tick !== 1'b1; n = n + 1) cyc(1);
         chk(n[23:0], 24'd8 << i);
         chk(low_power_rate_code, i[1:0]);
      end
      chk(track_step, 3'h5);
      low_power_mode = 1'b0;
      cyc(2);
      chk(track_step, 3'h3);
   endtask
   task t_restart;
      for (i = 0; i < 2; i = i + 1) begin
         host.wr(8'h11, i ? 8'h08 : 8'h18);
         low_power_mode = 1'b1;
         cyc(4);
         low_power_mode = 1'b0;
         for (n = 0; n < 4 && algorithm_state_reset !== 1'b1; n = n + 1) cyc(1);
         chk({algorithm_state_reset, baseline_reset}, i ? 5'h1a : 5'h1f);
      end
   endtask
   task t_int;
      host.wr(8'h11, 8'h10);
      button_detect = 4'hf;
      cyc(3);
      chk({raw_data_select, button_out, interrupt_output}, 6'h21);
      for (i = 0; i < 4; i = i + 1) begin
         if (i == 3) host.wr(8'h11, 8'h14);
         cyc(2);
         chk(interrupt_output, i != 3);
         capture_done = (i == 1) ? 4'h0 : 4'h1 << (i == 2);
         error_event = (i == 1);
         cyc(1);
         capture_done = 4'h0;
         error_event = 1'b0;
         cyc(1);
         chk(interrupt_output, i >= 2);
         int_ack = 1'b1;
         cyc(1);
         int_ack = 1'b0;
      end
      button_detect = 4'h0;
   endtask
   task t_alg;
      for (i = 0; i < 2; i = i + 1) begin
         host.wr(8'h11, i ? 8'h1a : 8'h18);
         button_detect = 4'h1;
         cyc(3);
         chk(button_out, 4'h1);
         cyc(25);
         chk(button_out, {3'h0, i[0]});
         button_detect = 4'h0;
         cyc(3);
      end
   endtask
   task t_range;
      for (i = 0; i < 2; i = i + 1) begin
         host.wr(8'h11, i ? 8'h19 : 8'h18);
         cyc(2);
         range_violation = 1'b1;
         cyc(1);
         range_violation = 1'b0;
         cyc(2);
         chk(max_output_flag, !i[0]);
         max_output_clear = 1'b1;
         cyc(1);
         max_output_clear = 1'b0;
         cyc(1);
         chk(max_output_flag, 1'b0);
      end
   endtask
   // Whole run is under a thousand cycles; allow four times that
   initial begin
      #400000;
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
   initial begin
      {arst_n, low_power_mode, error_event, range_violation, int_ack, max_output_clear} = 6'h0;
      channel_enable = 4'h5;
      button_detect = 4'h0;
      capture_done = 4'h0;
      n_mismatch = 0;
      checks = 0;
      cyc(2);
      arst_n = 1'b1;
      cyc(3);
      t_reset;
      t_rw;
      t_rate;
      t_restart;
      t_int;
      t_alg;
      t_range;
      end_of_test;
   end
endmodule // tb_top
bind bac_config_regs bac_checker chk_i (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rvalid, .low_power_mode, .channel_enable, .capture_done, .error_event,
   .range_violation, .int_ack, .max_output_clear, .button_out, .interrupt_output,
   .max_output_flag, .raw_data_select, .algorithm_state_reset, .baseline_reset);

// >>> verilog/bac_config_regs.v
`timescale 1ns/1ps
`include "bac_regs.vh"

module bac_config_regs #(
   parameter LP_BASE_CYCLES = `BAC_LP_BASE_CYCLES,
   parameter TIMEOUT_CYCLES = `BAC_TIMEOUT_CYCLES
) (
   input  wire        clock,
   input  wire        arst_n,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   input  wire        low_power_mode,
   input  wire [3:0]  channel_enable,
   input  wire [3:0]  button_detect,
   input  wire [3:0]  capture_done,
   input  wire        error_event,
   input  wire        range_violation,
   input  wire        int_ack,
   input  wire        max_output_clear,
   output reg  [3:0]  button_out,
   output reg         interrupt_output,
   output reg         max_output_flag,
   output reg         raw_data_select,
   output reg         lp_sample_tick,
   output reg  [1:0]  low_power_rate_code,
   output reg  [2:0]  track_step,
   output reg         algorithm_state_reset,
   output reg  [3:0]  baseline_reset,
   output reg  [5:0]  channel0_sensitivity,
   output reg  [5:0]  channel1_sensitivity,
   output reg  [5:0]  channel2_sensitivity,
   output reg  [5:0]  channel3_sensitivity,
   output reg  [7:0]  tracking_pause_and_group
);

   reg         rst_meta_n;
   reg         rst_sync_n;
   reg  [7:0]  lp_rate_reg;
   reg  [7:0]  int_alg_ctrl_reg;
   reg  [7:0]  lp_step_reg;
   reg  [7:0]  np_step_reg;
   reg  [7:0]  track_pause_reg;
   reg  [7:0]  rdata_next;
   reg  [31:0] scan_count_reg;
   reg  [31:0] scan_limit;
   reg         low_power_prev_reg;
   reg         int_pending_reg;
   reg         int_pending_next;
   reg         max_flag_next;
   reg  [3:0]  pressed_reg;
   wire [7:0]  gain_word [0:3];
   wire [5:0]  gain_field [0:3];
   wire [3:0]  timed_out;
   wire [3:0]  button_live;
   wire        alg_en;
   wire        restart_en;
   wire        int_active_high;
   wire        timeout_dis;
   wire        range_dis;
   wire        int_event;
   wire        lp_exit;

   assign alg_en          = int_alg_ctrl_reg[`BAC_BIT_ALG_EN];
   assign restart_en      = int_alg_ctrl_reg[`BAC_BIT_RESTART_EN];
   assign int_active_high = int_alg_ctrl_reg[`BAC_BIT_INT_POL];
   assign timeout_dis     = int_alg_ctrl_reg[`BAC_BIT_TO_DIS];
   assign range_dis       = int_alg_ctrl_reg[`BAC_BIT_RANGE_DIS];
   assign lp_exit         = low_power_prev_reg & ~low_power_mode;

   // Reset release through two flops
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Per-channel gain register and press timeout
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_channel
         reg  [7:0]  gain_reg;
         reg  [31:0] held_count_reg;
         reg         timed_out_reg;
         wire [7:0]  ofs;
         assign ofs = (ch == 0) ? `BAC_OFS_CH0_GAIN :
                      (ch == 1) ? `BAC_OFS_CH1_GAIN :
                      (ch == 2) ? `BAC_OFS_CH2_GAIN : `BAC_OFS_CH3_GAIN;
         always @(posedge clock or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               gain_reg <= `BAC_RST_GAIN;
            end else if (reg_write && reg_addr == ofs) begin
               gain_reg <= reg_wdata;
            end
         end
         assign gain_word[ch]  = gain_reg;
         assign gain_field[ch] = gain_reg[`BAC_GAIN_MSB:0];
         // Releasing the button rearms the timeout
         always @(posedge clock or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               held_count_reg <= 32'h00000000;
               timed_out_reg  <= 1'b0;
            end else if (!button_detect[ch]) begin
               held_count_reg <= 32'h00000000;
               timed_out_reg  <= 1'b0;
            end else if (timeout_dis) begin
               held_count_reg <= 32'h00000000;
               timed_out_reg  <= 1'b0;
            end else if (held_count_reg >= TIMEOUT_CYCLES) begin
               timed_out_reg  <= 1'b1;
            end else begin
               held_count_reg <= held_count_reg + 32'h00000001;
            end
         end
         assign timed_out[ch] = timed_out_reg;
      end
   endgenerate

   // Low power scan rate; reserved bits kept as written
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lp_rate_reg <= `BAC_RST_LP_RATE;
      end else if (reg_write && reg_addr == `BAC_OFS_LP_RATE) begin
         lp_rate_reg <= reg_wdata;
      end
   end

   // Interrupt and algorithm control
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         int_alg_ctrl_reg <= `BAC_RST_INT_ALG_CTRL;
      end else if (reg_write && reg_addr == `BAC_OFS_INT_ALG_CTRL) begin
         int_alg_ctrl_reg <= reg_wdata;
      end
   end

   // Low power tracking step
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lp_step_reg <= `BAC_RST_LP_STEP;
      end else if (reg_write && reg_addr == `BAC_OFS_LP_STEP) begin
         lp_step_reg <= reg_wdata;
      end
   end

   // Normal power tracking step
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         np_step_reg <= `BAC_RST_NP_STEP;
      end else if (reg_write && reg_addr == `BAC_OFS_NP_STEP) begin
         np_step_reg <= reg_wdata;
      end
   end

   // Tracking pause and group word, only stored and passed on
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         track_pause_reg <= `BAC_RST_TRACK_PAUSE;
      end else if (reg_write && reg_addr == `BAC_OFS_TRACK_PAUSE) begin
         track_pause_reg <= reg_wdata;
      end
   end

   // Read mux; reserved bits read back as stored, unmapped reads zero
   always @* begin
      if (reg_addr == `BAC_OFS_CH0_GAIN) begin
         rdata_next = gain_word[0];
      end else if (reg_addr == `BAC_OFS_LP_RATE) begin
         rdata_next = lp_rate_reg;
      end else if (reg_addr == `BAC_OFS_CH1_GAIN) begin
         rdata_next = gain_word[1];
      end else if (reg_addr == `BAC_OFS_INT_ALG_CTRL) begin
         rdata_next = int_alg_ctrl_reg;
      end else if (reg_addr == `BAC_OFS_CH2_GAIN) begin
         rdata_next = gain_word[2];
      end else if (reg_addr == `BAC_OFS_LP_STEP) begin
         rdata_next = lp_step_reg;
      end else if (reg_addr == `BAC_OFS_CH3_GAIN) begin
         rdata_next = gain_word[3];
      end else if (reg_addr == `BAC_OFS_NP_STEP) begin
         rdata_next = np_step_reg;
      end else if (reg_addr == `BAC_OFS_TRACK_PAUSE) begin
         rdata_next = track_pause_reg;
      end else begin
         rdata_next = 8'h00;
      end
   end

   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   // Sample period doubles with each code step from 5 SPS
   always @* begin
      scan_limit = LP_BASE_CYCLES << lp_rate_reg[`BAC_RATE_MSB:0];
   end

   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         scan_count_reg <= 32'h00000000;
         lp_sample_tick <= 1'b0;
      end else if (!low_power_mode || scan_count_reg >= scan_limit - 32'h00000001) begin
         scan_count_reg <= 32'h00000000;
         lp_sample_tick <= low_power_mode;
      end else begin
         scan_count_reg <= scan_count_reg + 32'h00000001;
         lp_sample_tick <= 1'b0;
      end
   end

   // Timed-out buttons drop until released
   assign button_live = button_detect & ~timed_out & channel_enable;

   // Interrupt source depends on algorithm mode
   assign int_event = alg_en ? (|(button_live ^ pressed_reg))
                             : ((|(capture_done & channel_enable)) | error_event);

   // Set wins over acknowledge
   always @* begin
      int_pending_next = int_pending_reg;
      if (int_event) begin
         int_pending_next = 1'b1;
      end else if (int_ack) begin
         int_pending_next = 1'b0;
      end
   end

   // Set wins over clear
   always @* begin
      max_flag_next = max_output_flag;
      if (alg_en && range_violation && !range_dis) begin
         max_flag_next = 1'b1;
      end else if (max_output_clear) begin
         max_flag_next = 1'b0;
      end
   end

   // Button pins and raw data select
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pressed_reg     <= 4'h0;
         button_out      <= 4'h0;
         raw_data_select <= 1'b0;
      end else begin
         pressed_reg     <= alg_en ? button_live : 4'h0;
         button_out      <= alg_en ? button_live : 4'h0;
         raw_data_select <= ~alg_en;
      end
   end

   // Interrupt pin and sticky range flag
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         int_pending_reg  <= 1'b0;
         interrupt_output <= 1'b1;
         max_output_flag  <= 1'b0;
      end else begin
         int_pending_reg  <= int_pending_next;
         interrupt_output <= int_active_high ? int_pending_reg
                                             : ~int_pending_reg;
         max_output_flag  <= max_flag_next;
      end
   end

   // Return from low power restarts the algorithm
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_power_prev_reg    <= 1'b0;
         algorithm_state_reset <= 1'b0;
         baseline_reset        <= 4'h0;
      end else begin
         low_power_prev_reg    <= low_power_mode;
         algorithm_state_reset <= lp_exit;
         if (lp_exit) begin
            baseline_reset <= restart_en ? 4'hf
                                         : ~channel_enable;
         end else begin
            baseline_reset <= 4'h0;
         end
      end
   end

   // Rate code and tracking step out
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_power_rate_code      <= 2'h0;
         track_step               <= 3'h0;
         tracking_pause_and_group <= 8'h00;
      end else begin
         low_power_rate_code      <= lp_rate_reg[`BAC_RATE_MSB:0];
         track_step               <= low_power_mode ? lp_step_reg[`BAC_STEP_MSB:0]
                                                    : np_step_reg[`BAC_STEP_MSB:0];
         tracking_pause_and_group <= track_pause_reg;
      end
   end

   // Channel gain fields out
   always @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         channel0_sensitivity <= 6'h00;
         channel1_sensitivity <= 6'h00;
         channel2_sensitivity <= 6'h00;
         channel3_sensitivity <= 6'h00;
      end else begin
         channel0_sensitivity <= gain_field[0];
         channel1_sensitivity <= gain_field[1];
         channel2_sensitivity <= gain_field[2];
         channel3_sensitivity <= gain_field[3];
      end
   end

endmodule // bac_config_regs

// >>> verilog/bac_regs.vh
`ifndef BAC_REGS_VH
`define BAC_REGS_VH

// Register offsets
`define BAC_OFS_CH0_GAIN      8'h0e
`define BAC_OFS_LP_RATE       8'h0f
`define BAC_OFS_CH1_GAIN      8'h10
`define BAC_OFS_INT_ALG_CTRL  8'h11
`define BAC_OFS_CH2_GAIN      8'h12
`define BAC_OFS_LP_STEP       8'h13
`define BAC_OFS_CH3_GAIN      8'h14
`define BAC_OFS_NP_STEP       8'h15
`define BAC_OFS_TRACK_PAUSE   8'h16

// Reset values
`define BAC_RST_GAIN          8'h28
`define BAC_RST_LP_RATE       8'h10
`define BAC_RST_INT_ALG_CTRL  8'h18
`define BAC_RST_LP_STEP       8'h05
`define BAC_RST_NP_STEP       8'h03
`define BAC_RST_TRACK_PAUSE   8'h00

// Field positions
`define BAC_GAIN_MSB          5
`define BAC_RATE_MSB          1
`define BAC_STEP_MSB          2
`define BAC_BIT_RESTART_EN    4
`define BAC_BIT_ALG_EN        3
`define BAC_BIT_INT_POL       2
`define BAC_BIT_TO_DIS        1
`define BAC_BIT_RANGE_DIS     0

// Timing: clock rate, fastest-code (code 0) base period and button timeout
`define BAC_CLOCK_HZ          10000000
`define BAC_LP_BASE_PERIOD_MS 200
`define BAC_BUTTON_TIMEOUT_S  50
`define BAC_LP_BASE_CYCLES    (`BAC_CLOCK_HZ / 1000 * `BAC_LP_BASE_PERIOD_MS)
`define BAC_TIMEOUT_CYCLES    (`BAC_CLOCK_HZ * `BAC_BUTTON_TIMEOUT_S)

`endif
